//--- dv/link_host_control_assertions.sv
// Purpose: Port checks for the host control register bank.
// Assumes: Zero-wait APB slave; link answers one cycle after cause.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ns
`default_nettype none
`include "host_ctl_defs.vh"

module link_host_control_checker #(
    parameter [31:0] VENDOR_CODE = 32'h00A5_0001 // Arbitrary value
) (
    input wire        clock,          // System clock
    input wire        rst_n,          // Reset, active low
    input wire        enable,         // Clock enable
    input wire        psel,           // APB select
    input wire        penable,        // APB access phase
    input wire        pwrite,         // APB write
    input wire [7:0]  paddr,          // APB address
    input wire [31:0] prdata,         // APB read data
    input wire        pready,         // APB ready
    input wire        pslverr,        // APB error
    input wire        rom_read_req,   // ROM read arrived
    input wire        node_async_req, // Node packet arrived
    input wire        rom_read_ack,   // ROM read served
    input wire        rom_type_error, // ROM read refused
    input wire        late_ack_sent,  // Tardy acknowledge
    input wire        irq             // Interrupt level
);
    // One clock domain; reset silences every check
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Address decode seen in the access cycle
    wire rd  = pready && !pwrite;
    wire ctl = paddr == `OFS_HOST_CONTROL_SET
            || paddr == `OFS_HOST_CONTROL_CLEAR;
    wire map = ctl || paddr == `OFS_VENDOR_IDENTITY
            || paddr == `OFS_EVENT_STATUS || paddr == `OFS_EVENT_MASK;

    a_ready_after_setup: assert property (
        psel && !penable && enable |=> pready)
        else $error("pready late after setup");
    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("pready held too long");
    a_error_unmapped: assert property (
        pready |-> pslverr == !map)
        else $error("pslverr wrong for address");
    a_vendor_fixed: assert property (
        rd && paddr == `OFS_VENDOR_IDENTITY |-> prdata == VENDOR_CODE)
        else $error("identity word wrong");
    a_reserved_zero: assert property (
        rd && ctl |-> prdata[28:24] == 5'h0)
        else $error("reserved control bits not zero");
    a_read_ack_cause: assert property (
        rom_read_ack |-> $past(rom_read_req))
        else $error("ROM answer without request");
    a_type_err_cause: assert property (
        rom_type_error |-> $past(rom_read_req) && !rom_read_ack)
        else $error("type error without request");
    a_late_ack_cause: assert property (
        late_ack_sent |-> $past(node_async_req))
        else $error("tardy ack unasked");

    // Main scenarios reached
    c_rom_served: cover property (rom_read_ack);
    c_rom_refused: cover property (rom_type_error);
    c_late_ack: cover property (late_ack_sent);
    c_irq: cover property (irq);
endmodule // link_host_control_checker

bind link_host_control link_host_control_checker #(
    .VENDOR_CODE(VENDOR_CODE)) i_chk (.clock(clock), .rst_n(rst_n),
    .enable(enable), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_read_req(rom_read_req), .node_async_req(node_async_req),
    .rom_read_ack(rom_read_ack), .rom_type_error(rom_type_error),
    .late_ack_sent(late_ack_sent), .irq(irq));
`default_nettype wire

//--- dv/remote_node.sv
// Purpose: Remote serial-bus node sending requests to the link.
// Assumes: Requests are one-cycle pulses on the system clock.
// Notes:   Answers are collected in the cycle after the request.
`timescale 1ns/1ns
`default_nettype none

module remote_node (
    input  wire  clock,           // System clock
    input  wire  rom_read_ack,    // Block read served
    input  wire  rom_type_error,  // Block read refused
    input  wire  late_ack_sent,   // Tardy acknowledge
    input  wire  rom_regs_update, // ROM registers reloaded
    output logic rom_read_req,    // Block read of host ROM
    output logic node_async_req,  // Other packet to this node
    output logic bus_reset        // Serial bus reset
);
    initial {rom_read_req, node_async_req, bus_reset} = 3'b000;

    // Kind 0 ROM read, 1 node packet, 2 bus reset; one request a call
    task automatic send(input int kind, output logic [3:0] ans);
        @(posedge clock);
        rom_read_req <= kind == 0;
        node_async_req <= kind == 1;
        bus_reset <= kind == 2;
        @(posedge clock);
        {rom_read_req, node_async_req, bus_reset} <= 3'b000;
        #1 ans = {rom_regs_update, late_ack_sent, rom_type_error,
                  rom_read_ack};
    endtask
endmodule // remote_node
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Register and link event tests of the host control bank.
// Assumes: Zero-wait APB; strap pins driven by the bench.
// Notes:   Bit 19 is expected settable and clearable.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam [31:0] VENDOR = 32'h00A5_0001; // Arbitrary identity
    localparam [7:0] VID = 8'h40, SET = 8'h50, CLR = 8'h54;
    localparam [7:0] STAT = 8'h80, MASK = 8'h88;
    logic        clock = 1'b0, rst_n = 1'b0;      // Clock and reset
    logic        psel = 1'b0, penable = 1'b0;     // APB control
    logic        pwrite = 1'b0, slverr;           // Direction, error seen
    logic [7:0]  paddr = 8'h00;                   // APB address
    logic [31:0] pwdata = 32'h0000_0000, rdata;   // Write and read data
    logic        strap = 1'b0, loaded = 1'b0;     // Serial ROM pins
    logic        fetch_err = 1'b0;                // Host memory fault
    logic        en = 1'b1;                       // Clock enable
    logic [3:0]  ans;                             // Link answer
    wire  [31:0] prdata;
    wire         pready, pslverr, rom_read_req, node_async_req, bus_reset;
    wire         rom_read_ack, rom_type_error, late_ack_sent, irq;
    wire         rom_regs_update, byte_swap_on, link_connected, link_clear;
    wire         rom_update_en;
    int          failures = 0, comparisons = 0, cycles = 0;

    always #50 clock = ~clock;

    link_host_control #(.VENDOR_CODE(VENDOR)) i_dut (.clock(clock),
        .rst_n(rst_n), .enable(en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .delegate_strap(strap),
        .strap_loaded(loaded), .rom_fetch_error(fetch_err),
        .rom_read_req(rom_read_req), .node_async_req(node_async_req),
        .bus_reset(bus_reset), .rom_read_ack(rom_read_ack),
        .rom_type_error(rom_type_error), .late_ack_sent(late_ack_sent),
        .rom_regs_update(rom_regs_update), .rom_update_en(rom_update_en),
        .byte_swap_on(byte_swap_on), .link_connected(link_connected),
        .link_clear(link_clear), .irq(irq));

    remote_node i_node (.clock(clock), .rom_read_ack(rom_read_ack),
        .rom_type_error(rom_type_error), .late_ack_sent(late_ack_sent),
        .rom_regs_update(rom_regs_update), .rom_read_req(rom_read_req),
        .node_async_req(node_async_req), .bus_reset(bus_reset));

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read a register and compare it
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check($sformatf("reg %h", a), exp, rdata);
    endtask

    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard; the tests need well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rchk(VID, VENDOR);
        apb(1'b1, VID, 32'hFFFF_FFFF);
        rchk(VID, VENDOR);
        rchk(CLR, 32'h0080_0000);
        apb(1'b0, 8'h44, 32'h0000_0000);
        check("slverr", 32'(1), 32'(slverr));
        // Link still inactive and node not bus manager here
        apb(1'b1, SET, 32'hE04E_0000);
        rchk(CLR, 32'hE0CE_0000);
        check("update en", 32'(1), 32'(rom_update_en));
        check("connected", 32'(1), 32'(link_connected));
        check("swap", 32'(0), 32'(byte_swap_on));
        apb(1'b1, CLR, 32'hC000_0000);
        rchk(SET, 32'hA0CE_0000);
        check("swap", 32'(1), 32'(byte_swap_on));
        i_node.send(0, ans);
        check("rom served", 32'h1, 32'(ans));
        i_node.send(2, ans);
        check("rom regs reload", 32'h8, 32'(ans));
        // Frozen by the clock enable: a ROM read must go unanswered
        @(posedge clock);
        en <= 1'b0;
        i_node.send(0, ans);
        check("frozen", 32'h0, 32'(ans));
        en <= 1'b1;
        apb(1'b1, MASK, 32'h0000_0001);
        i_node.send(1, ans);
        check("late ack", 32'h4, 32'(ans));
        repeat (2) @(posedge clock);
        #1 check("irq", 32'(1), 32'(irq));
        rchk(STAT, 32'h1);
        rchk(STAT, 32'h0);
        check("irq", 32'(0), 32'(irq));
        fetch_err <= 1'b1;
        @(posedge clock);
        fetch_err <= 1'b0;
        rchk(SET, 32'h20CE_0000);
        check("update en", 32'(0), 32'(rom_update_en));
        rchk(STAT, 32'h2);
        i_node.send(0, ans);
        check("rom refused", 32'h2, 32'(ans));
        i_node.send(2, ans);
        check("rom regs frozen", 32'h0, 32'(ans));
        apb(1'b1, CLR, 32'h0002_0000);
        i_node.send(0, ans);
        check("link off", 32'h0, 32'(ans));
        check("connected", 32'(0), 32'(link_connected));
        apb(1'b1, SET, 32'h0001_0000);
        rchk(SET, 32'h0081_0000);
        check("link clear", 32'(1), 32'(link_clear));
        repeat (12) @(posedge clock);
        rchk(SET, 32'h0080_0000);
        check("link clear", 32'(0), 32'(link_clear));
        rchk(MASK, 32'h0);
        loaded <= 1'b1;
        repeat (4) @(posedge clock);
        rchk(SET, 32'h0000_0000);
        end_sim();
    end
endmodule // testbench
`default_nettype wire

//--- logic/host_ctl_defs.vh
// Purpose: Offsets, field positions, reset values and timing counts for
//          the link host control register bank.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef HOST_CTL_DEFS_VH
`define HOST_CTL_DEFS_VH

// Register byte offsets
`define OFS_VENDOR_IDENTITY    8'h40
`define OFS_HOST_CONTROL_SET   8'h50
`define OFS_HOST_CONTROL_CLEAR 8'h54
`define OFS_EVENT_STATUS       8'h80
`define OFS_EVENT_MASK         8'h88

// Host control field positions
`define BIT_ROM_IMAGE_VALID      31
`define BIT_DATA_SWAP_DISABLE    30
`define BIT_LATE_ACK_ENABLE      29
`define BIT_PHY_CONFIG_DELEGATED 23
`define BIT_PHY_ENHANCEMENT_ON   22
`define BIT_LINK_POWER_ON        19
`define BIT_POSTED_WRITE_ENABLE  18
`define BIT_LINK_ACTIVE          17
`define BIT_SOFTWARE_CLEAR       16

// Bits that both set and clear addresses may change
`define HOST_CONTROL_RSC_MASK 32'h604E_0000

// Event status field positions
`define EVT_LATE_ACK   0
`define EVT_ROM_FETCH  1
`define EVT_WIDTH      2

// Reset values (bits shown as unknown reset to zero here)
`define HOST_CONTROL_RESET 32'h0000_0000
`define EVENT_MASK_RESET   2'h0
`define DELEGATED_RESET    1'b1

// Software reset length in clock cycles
`define SOFT_RESET_CYCLES 4'h8

`endif

//--- logic/link_host_control.v
// Purpose: Host control register bank of a serial-bus link controller:
//          identity word, set/clear control pair, event status and mask.
// Assumes: APB slave with zero wait states; link events arrive as
//          one-cycle pulses on the same clock; the strap is a pin.
// Notes:   Read of the event status clears it; a new event beats the
//          read clear. A software clear empties control, status and
//          mask, and holds the link off while its timer runs.
`timescale 1ns/1ns
`default_nettype none
`include "host_ctl_defs.vh"

// Functional notes
// - Identity word is fixed, writes ignored
// - Set address and clear address for flags
// - Image valid software set, hardware cleared
// - Image valid enables ROM block reads
// - Image invalid answers type error
// - Image invalid freezes ROM registers on reset
// - Resets and fetch error clear image valid
// - Swap disable controls DMA byte swapping
// - Late ack enable answers node packets tardy
// - Each tardy ack sets event flag
// - Bits 28 to 24 read zero
// - Delegation flag loaded, defaults to one
// - Link inactive disconnects from serial bus
// - Software clear resets link, reads busy
module link_host_control #(
    parameter [31:0] VENDOR_CODE = 32'h00A5_0001 // Arbitrary identity value
) (
    input  wire        clock,          // 10 MHz system clock
    input  wire        rst_n,          // Asynchronous reset, active low
    input  wire        enable,         // Clock enable, freezes all state
    input  wire        psel,           // APB select
    input  wire        penable,        // APB access phase
    input  wire        pwrite,         // APB write
    input  wire [7:0]  paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    output reg  [31:0] prdata,         // APB read data
    output reg         pready,         // APB ready
    output reg         pslverr,        // APB error, unmapped address
    input  wire        delegate_strap, // Serial ROM delegation level, pin
    input  wire        strap_loaded,   // Serial ROM load done, pin
    input  wire        rom_fetch_error,// Info block fetch failed, pulse
    input  wire        rom_read_req,   // ROM block read arrived, pulse
    input  wire        node_async_req, // Async packet to this node, pulse
    input  wire        bus_reset,      // Serial bus reset, pulse
    output reg         rom_read_ack,   // ROM block read answered, pulse
    output reg         rom_type_error, // ROM read refused, pulse
    output reg         late_ack_sent,  // Tardy acknowledge sent, pulse
    output reg         rom_regs_update,// Reload ROM registers, pulse
    output reg         rom_update_en,  // Atomic ROM update enabled
    output reg         byte_swap_on,   // DMA data swapped
    output reg         link_connected, // Link may move packets
    output reg         link_clear,     // Link state and FIFO flush
    output reg         irq             // Level interrupt
);

    reg  [31:0] ctl_q;                 // Host control flags
    reg  [31:0] ctl_d;                 // Next host control flags
    reg  [1:0]  evt_q;                 // Sticky event status
    reg  [1:0]  evt_d;                 // Next event status
    reg  [1:0]  mask_q;                // Event mask
    reg         deleg_q;               // Delegation flag
    reg         strap_seen_q;          // Strap already captured
    reg         sr_start_q;            // Software reset start pulse
    reg  [31:0] rd_d;                  // Read mux
    reg         hit_d;                 // Address is mapped
    wire        delegate_s;            // Synchronised strap level
    wire        loaded_s;              // Synchronised load done
    wire        sr_busy;               // Software reset in progress
    wire        wr_acc;                // Write access phase
    wire        rd_acc;                // Read access phase
    wire        link_on;               // Link active and not clearing
    wire        late_ack_d;            // Tardy acknowledge now

    // Access phase decode; a write lands on the edge that ends it
    assign wr_acc  = psel & penable & pwrite;
    assign rd_acc  = psel & penable & ~pwrite;
    assign link_on = ctl_q[`BIT_LINK_ACTIVE] & ~sr_busy;
    // Tardy answers only while the link moves packets at all
    assign late_ack_d = link_on & node_async_req
                      & ctl_q[`BIT_LATE_ACK_ENABLE];

    // Strap pins cross into the clock domain first
    sync_two_ff u_sync_deleg (
        .clock    (clock),
        .rst_n    (rst_n),
        .enable   (enable),
        .async_in (delegate_strap),
        .sync_out (delegate_s)
    );

    sync_two_ff u_sync_loaded (
        .clock    (clock),
        .rst_n    (rst_n),
        .enable   (enable),
        .async_in (strap_loaded),
        .sync_out (loaded_s)
    );

    // Times the software clear so the flag reads busy meanwhile
    soft_reset_timer u_soft_reset (
        .clock  (clock),
        .rst_n  (rst_n),
        .enable (enable),
        .start  (sr_start_q),
        .busy   (sr_busy)
    );

    // Next value of the control flags. Only the read/set/clear bits take
    // bus writes; the image-valid bit is set by software but cleared only
    // by hardware, so a clear-address write leaves it alone.
    always @* begin
        ctl_d = ctl_q;
        if (wr_acc && paddr == `OFS_HOST_CONTROL_SET) begin
            ctl_d = ctl_q | (pwdata & `HOST_CONTROL_RSC_MASK);
            if (pwdata[`BIT_ROM_IMAGE_VALID]) begin
                ctl_d[`BIT_ROM_IMAGE_VALID] = 1'b1;
            end
        end else if (wr_acc && paddr == `OFS_HOST_CONTROL_CLEAR) begin
            ctl_d = ctl_q & ~(pwdata & `HOST_CONTROL_RSC_MASK);
        end
        // A failed info-block fetch beats a set in the same cycle: the
        // image in memory is known bad, so answering from it is unsafe
        if (rom_fetch_error) begin
            ctl_d[`BIT_ROM_IMAGE_VALID] = 1'b0;
        end
        // Software clear wins over everything above
        if (sr_start_q) begin
            ctl_d = `HOST_CONTROL_RESET;
        end
        // Only writable positions are ever held; the rest read as zero,
        // which keeps the reserved field empty without a read-side mask
        ctl_d = ctl_d & (`HOST_CONTROL_RSC_MASK | 32'h8000_0000);
    end

    // Next value of the event status; a new event beats the read clear
    always @* begin
        evt_d = evt_q;
        if (rd_acc && paddr == `OFS_EVENT_STATUS) begin
            evt_d = 2'h0;
        end
        // A software clear empties the status like the control flags and mask
        if (sr_start_q) begin
            evt_d = 2'h0;
        end
        if (late_ack_d) begin
            evt_d[`EVT_LATE_ACK] = 1'b1;
        end
        if (rom_fetch_error) begin
            evt_d[`EVT_ROM_FETCH] = 1'b1;
        end
    end

    // Read data mux; control bits and delegation are merged in
    always @* begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            `OFS_VENDOR_IDENTITY: begin
                // Fixed word; no write path reaches it
                rd_d = VENDOR_CODE;
            end
            `OFS_HOST_CONTROL_SET, `OFS_HOST_CONTROL_CLEAR: begin
                // Both addresses read the same flags
                rd_d = ctl_q;
                rd_d[`BIT_PHY_CONFIG_DELEGATED] = deleg_q;
                rd_d[`BIT_SOFTWARE_CLEAR] = sr_busy | sr_start_q;
            end
            `OFS_EVENT_STATUS: begin
                rd_d = {{30{1'b0}}, evt_q}; // Sticky events
            end
            `OFS_EVENT_MASK: begin
                rd_d = {{30{1'b0}}, mask_q}; // Event mask
            end
            default: begin
                // Unmapped: reads zero and answers with an error
                hit_d = 1'b0;
            end
        endcase
    end

    // Control flags and sticky events move together on each enabled edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `HOST_CONTROL_RESET;
            evt_q <= 2'h0;                // No event pending
        end else if (enable) begin
            ctl_q <= ctl_d;               // Writes and hardware clears
            evt_q <= evt_d;               // Events set, status read clears
        end
    end

    // Event mask; a software clear puts it back to its reset value
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `EVENT_MASK_RESET;
        end else if (enable) begin
            if (sr_start_q) begin
                mask_q <= `EVENT_MASK_RESET;
            end else if (wr_acc && paddr == `OFS_EVENT_MASK) begin
                mask_q <= pwdata[`EVT_WIDTH-1:0]; // Whole mask replaced
            end
        end
    end

    // Delegation flag: reads one until the serial ROM load is seen, then
    // takes the strap once. Later strap movement is ignored on purpose,
    // so a bouncing pin cannot flip the flag under a running driver.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            deleg_q      <= `DELEGATED_RESET;
            strap_seen_q <= 1'b0;
        end else if (enable) begin
            if (loaded_s && !strap_seen_q) begin
                deleg_q      <= delegate_s;
                strap_seen_q <= 1'b1;       // Capture only once
            end
        end
    end

    // Software clear start: one pulse per accepted request. A request
    // while a clear runs is dropped; restarting the timer would stretch
    // the busy time for as long as software keeps writing.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sr_start_q <= 1'b0;
        end else if (enable) begin
            sr_start_q <= wr_acc && paddr == `OFS_HOST_CONTROL_SET
                        && pwdata[`BIT_SOFTWARE_CLEAR]
                        && !sr_busy && !sr_start_q;
        end
    end

    // Bus answer: the setup phase raises ready, so every access ends
    // after one access cycle. Read data is captured at setup, so a
    // status read returns the events seen before its own clear.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (enable) begin
            pready  <= psel & ~penable;          // Access phase next
            pslverr <= psel & ~penable & ~hit_d; // Unmapped address
            if (psel && !penable && !pwrite) begin
                prdata <= rd_d;                  // Read of this setup
            end
        end
    end

    // Serial-bus answers, one cycle after the request
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rom_read_ack    <= 1'b0;
            rom_type_error  <= 1'b0;
            late_ack_sent   <= 1'b0;
            rom_regs_update <= 1'b0;
        end else if (enable) begin
            // ROM reads while the link is on: answered when image valid, refused otherwise
            rom_read_ack   <= link_on & rom_read_req
                            & ctl_q[`BIT_ROM_IMAGE_VALID];
            rom_type_error <= link_on & rom_read_req
                            & ~ctl_q[`BIT_ROM_IMAGE_VALID];
            late_ack_sent  <= late_ack_d;
            // ROM registers only reload on bus reset with a valid image
            rom_regs_update <= bus_reset
                             & ctl_q[`BIT_ROM_IMAGE_VALID];
        end
    end

    // Levels that follow the control flags, one cycle behind them
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rom_update_en  <= 1'b0;
            byte_swap_on   <= 1'b0;
            link_connected <= 1'b0;
            link_clear     <= 1'b0;
        end else if (enable) begin
            rom_update_en  <= ctl_q[`BIT_ROM_IMAGE_VALID];
            byte_swap_on   <= ~ctl_q[`BIT_DATA_SWAP_DISABLE];
            link_connected <= link_on;
            link_clear     <= sr_busy | sr_start_q;
        end
    end

    // Interrupt level; built from the next status so that a read clear
    // and the interrupt drop fall on the same edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (enable) begin
            irq <= |(evt_d & mask_q); // Unmasked sticky events
        end
    end

endmodule // link_host_control
`default_nettype wire

//--- logic/soft_reset_timer.v
// Purpose: Times the software-initiated clear of the link logic.
// Assumes: Start is a one-cycle pulse on the same clock.
// Notes:   Busy stays high for a fixed number of cycles.
`timescale 1ns/1ns
`default_nettype none
`include "host_ctl_defs.vh"

module soft_reset_timer (
    input  wire clock,      // System clock
    input  wire rst_n,      // Asynchronous reset, active low
    input  wire enable,     // Clock enable
    input  wire start,      // Begin a software reset
    output reg  busy        // High while the reset is in progress
);

    reg [3:0] count_q;      // Cycles left in the reset

    // Load on start, count down to zero, busy follows the count
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 4'h0;
            busy    <= 1'b0;
        end else if (enable) begin
            if (start) begin
                count_q <= `SOFT_RESET_CYCLES;
                busy    <= 1'b1;
            end else if (count_q != 4'h0) begin
                count_q <= count_q - 4'h1;
                busy    <= (count_q != 4'h1);
            end else begin
                busy    <= 1'b0;
            end
        end
    end

endmodule // soft_reset_timer
`default_nettype wire

//--- logic/sync_two_ff.v
// Purpose: Two flip-flop synchroniser for a single level.
// Assumes: Input is asynchronous to clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none

module sync_two_ff (
    input  wire clock,      // System clock
    input  wire rst_n,      // Asynchronous reset, active low
    input  wire enable,     // Clock enable
    input  wire async_in,   // Level from outside the domain
    output reg  sync_out    // Synchronised level
);

    reg meta_q;             // First stage, metastability catcher

    // Two stages in series
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else if (enable) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sync_two_ff
`default_nettype wire
